// ---- rtl/cgt_pkg.sv ----
// Package for the cascaded 32-bit gated timer: register map, fields, resets
package cgt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_COUNT_LOW   = 8'h00; // count_low_word
  localparam logic [7:0] OFS_COUNT_HIGH  = 8'h04; // count_high_word
  localparam logic [7:0] OFS_PERIOD_LOW  = 8'h08; // period_low_word
  localparam logic [7:0] OFS_PERIOD_HIGH = 8'h0c; // period_high_word
  localparam logic [7:0] OFS_LOWER_CTRL  = 8'h10; // lower_timer_control
  localparam logic [7:0] OFS_UPPER_CTRL  = 8'h14; // upper_timer_control
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18; // irq_flag_reg_zero, read only
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h1c; // irq_enable_reg_zero
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h20; // write one to clear
  localparam logic [7:0] OFS_SYS_CTRL    = 8'h24; // sleep and 32-bit mode
  // Control field positions
  localparam int CTL_TIMER_ON     = 15;
  localparam int CTL_GATE_ACC     = 6;
  localparam int CTL_PRESCALE_HI  = 5;
  localparam int CTL_PRESCALE_LO  = 4;
  localparam int CTL_MODE32       = 3;
  localparam int CTL_CLK_SOURCE   = 1;
  localparam int IRQ_PERIOD_BIT   = 7;
  localparam int SYS_SLEEP_BIT    = 0;
  // Reset values
  localparam logic [15:0] RST_COUNT  = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  // Instruction clock divides the oscillator by four
  localparam int INSTR_CLK_DIV = 4;
  // Prescale select codes
  typedef enum logic [1:0] {PS_DIV1, PS_DIV8, PS_DIV64, PS_DIV256} cgt_prescale_t;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- rtl/cgt_prescaler.sv ----
// Prescaler: divides a tick stream by 1, 8, 64 or 256
`timescale 1ns/1ns
`default_nettype none
module cgt_prescaler
  import cgt_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,       // Timer on; counter frozen otherwise
  input  wire logic       clear,     // Clear request from software writes
  input  wire logic       tick_in,   // Input clock enable
  input  wire logic [1:0] select,    // Prescale select code
  output logic            tick_out   // Divided one-cycle enable
);
  logic [7:0] cnt_r;  // Internal prescale count
  logic [7:0] limit;  // Last count before wrap

  // Terminal count per select code
  always_comb
  begin
    unique case (cgt_prescale_t'(select))
      PS_DIV1:   limit = 8'h00;
      PS_DIV8:   limit = 8'h07;
      PS_DIV64:  limit = 8'h3f;
      PS_DIV256: limit = 8'hff;
    endcase
  end

  // Count input ticks; clears only while running, since the clock is halted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= 8'h00;
    else if (run && clear)
      cnt_r <= 8'h00;
    else if (run && tick_in)
      cnt_r <= (cnt_r == limit) ? 8'h00 : cnt_r + 8'h01;
  end

  assign tick_out = run && tick_in && (cnt_r == limit);
endmodule // cgt_prescaler
`default_nettype wire

// ---- rtl/cgt_timer.sv ----
// Cascaded 32-bit gated timer with AXI4-Lite register slave
// Function
// - Gated mode counts instruction cycles while gate high
// - 32-bit mode: lower timer supplies clock, gate
// - Gate falling edge stops count, keeps value
// - ADC trigger pulse on 32-bit or upper 16-bit period match
// - Prescale divides by 1, 8, 64, 256
// - Clock source: instruction clock or external pin
// - 32-bit mode ignores upper prescale setting
// - Count, control writes or reset clear prescaler
// - Prescaler not cleared while timer off
// - Control writes leave counts unchanged
// - Sleep freezes the whole timer
// - Flag set on 32-bit period match or lower-timer gated-mode gate fall
// - Interrupt only when flag and enable set
`timescale 1ns/1ns
`default_nettype none
module cgt_timer
  import cgt_pkg::*;
#(
  parameter int OSC_DIV = INSTR_CLK_DIV  // aclk cycles per instruction cycle
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        gate_input_pin,   // Gate input, also external clock
  output logic             adc_trigger,      // One-cycle ADC start strobe
  output logic             irq               // Level interrupt request
);
  import cgt_pkg::*;

  // Registers
  logic [15:0] count_low_word_r;     // Lower count
  logic [15:0] count_high_word_r;    // Upper count
  logic [15:0] period_low_word_r;    // Lower period
  logic [15:0] period_high_word_r;   // Upper period
  logic [15:0] lower_ctrl_r;         // lower_timer_control
  logic [15:0] upper_ctrl_r;         // upper_timer_control
  logic [15:0] irq_flag_r;           // irq_flag_reg_zero
  logic [15:0] irq_enable_r;         // irq_enable_reg_zero
  logic [1:0]  sys_ctrl_r;           // Bit0 sleep, bit1 32-bit mode
  // Bus state
  logic        aw_full_r;            // Write address captured
  logic        w_full_r;             // Write data captured
  logic [7:0]  aw_addr_r;            // Captured write address
  logic [31:0] w_data_r;             // Captured write data
  logic [3:0]  w_strb_r;             // Captured strobes
  // Clock and edge logic
  logic [7:0]  instr_div_r;          // Instruction clock divider
  logic        gate_prev_r;          // Previous gate sample
  logic        instr_tick;           // Instruction-cycle enable
  logic        gate_fall;            // Gate falling edge
  logic        ext_tick;             // External pin rising edge
  logic        lo_src_tick;          // Lower input clock
  logic        hi_src_tick;          // Upper input clock
  logic        lo_tick;              // Lower prescaled tick
  logic        hi_tick;              // Upper prescaled tick (16-bit use)
  logic        mode32;               // Cascaded operation
  logic        sleeping;             // CPU sleep, clocks stopped
  logic        lo_on;                // Lower timer on
  logic        hi_on;                // Upper timer on
  logic        match32;              // 32-bit period match
  logic        match_hi;             // Upper 16-bit period match
  logic        wr_fire;              // Write commits this cycle
  logic        wr_lo_cnt;            // Write to count_low_word
  logic        wr_hi_cnt;            // Write to count_high_word
  logic        wr_lo_ctl;            // Write to lower control
  logic        wr_hi_ctl;            // Write to upper control
  logic        lo_ps_clr;            // Clear lower prescaler
  logic        hi_ps_clr;            // Clear upper prescaler
  logic        period_event;         // Period match on a counting tick

  // Merge strobed bytes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Write decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign sleeping = sys_ctrl_r[SYS_SLEEP_BIT];
  assign mode32   = sys_ctrl_r[1];
  assign lo_on    = lower_ctrl_r[CTL_TIMER_ON] && !sleeping;
  assign hi_on    = upper_ctrl_r[CTL_TIMER_ON] && !sleeping && !mode32;

  assign wr_fire   = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_lo_cnt = wr_fire && hit(aw_addr_r, OFS_COUNT_LOW);
  assign wr_hi_cnt = wr_fire && hit(aw_addr_r, OFS_COUNT_HIGH);
  assign wr_lo_ctl = wr_fire && hit(aw_addr_r, OFS_LOWER_CTRL);
  assign wr_hi_ctl = wr_fire && hit(aw_addr_r, OFS_UPPER_CTRL);
  assign lo_ps_clr = wr_lo_cnt || wr_hi_cnt || wr_lo_ctl || wr_hi_ctl;
  assign hi_ps_clr = lo_ps_clr;

  // Instruction clock: aclk divided by OSC_DIV, halted in sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr_div_r <= 8'h00;
    else if (!sleeping)
      instr_div_r <= (instr_div_r == 8'(OSC_DIV - 1)) ? 8'h00 : instr_div_r + 8'h01;
  end
  assign instr_tick = !sleeping && (instr_div_r == 8'(OSC_DIV - 1));

  // Gate pin history for edge detection; frozen in sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gate_prev_r <= 1'b0;
    else if (!sleeping)
      gate_prev_r <= gate_input_pin;
  end
  assign gate_fall = !sleeping && gate_prev_r && !gate_input_pin;
  assign ext_tick  = !sleeping && !gate_prev_r && gate_input_pin;

  // Lower input clock: gated instruction clock, instruction clock, or pin
  always_comb
  begin
    if (lower_ctrl_r[CTL_CLK_SOURCE])
      lo_src_tick = ext_tick;
    else if (lower_ctrl_r[CTL_GATE_ACC])
      lo_src_tick = instr_tick && gate_input_pin;
    else
      lo_src_tick = instr_tick;
  end

  // Upper input clock in 16-bit use; its gate bit is ignored when cascaded
  always_comb
  begin
    if (upper_ctrl_r[CTL_CLK_SOURCE])
      hi_src_tick = ext_tick;
    else if (upper_ctrl_r[CTL_GATE_ACC])
      hi_src_tick = instr_tick && gate_input_pin;
    else
      hi_src_tick = instr_tick;
  end

  // Lower prescaler also serves the whole 32-bit timer
  cgt_prescaler u_lo_ps (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (lo_on),
    .clear    (lo_ps_clr),
    .tick_in  (lo_src_tick),
    .select   (lower_ctrl_r[CTL_PRESCALE_HI:CTL_PRESCALE_LO]),
    .tick_out (lo_tick)
  );

  // Upper prescaler idles in 32-bit mode, so its select has no effect
  cgt_prescaler u_hi_ps (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (hi_on),
    .clear    (hi_ps_clr),
    .tick_in  (hi_src_tick),
    .select   (upper_ctrl_r[CTL_PRESCALE_HI:CTL_PRESCALE_LO]),
    .tick_out (hi_tick)
  );

  assign match32  = {count_high_word_r, count_low_word_r} == {period_high_word_r, period_low_word_r};
  assign match_hi = count_high_word_r == period_high_word_r;
  // Match is acted on at the tick that would step past the period
  assign period_event = mode32 ? (lo_tick && match32) : (hi_tick && match_hi);

  // Lower count: software write wins over counting; control writes leave it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_low_word_r <= RST_COUNT;
    else if (wr_lo_cnt)
      count_low_word_r <= merge16(count_low_word_r, w_data_r, w_strb_r);
    else if (lo_tick && mode32 && match32)
      count_low_word_r <= 16'h0000;
    else if (lo_tick && !(!mode32 && count_low_word_r == period_low_word_r))
      count_low_word_r <= count_low_word_r + 16'h0001;
    else if (lo_tick)
      count_low_word_r <= 16'h0000;
  end

  // Upper count: carry from lower in 32-bit mode, own clock otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_high_word_r <= RST_COUNT;
    else if (wr_hi_cnt)
      count_high_word_r <= merge16(count_high_word_r, w_data_r, w_strb_r);
    else if (mode32 && lo_tick)
    begin
      if (match32)
        count_high_word_r <= 16'h0000;
      else if (count_low_word_r == 16'hffff)
        count_high_word_r <= count_high_word_r + 16'h0001;
    end
    else if (!mode32 && hi_tick)
      count_high_word_r <= match_hi ? 16'h0000 : count_high_word_r + 16'h0001;
  end

  // Period and control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_low_word_r  <= RST_PERIOD;
      period_high_word_r <= RST_PERIOD;
      lower_ctrl_r       <= RST_CTRL;
      upper_ctrl_r       <= RST_CTRL;
      irq_enable_r       <= 16'h0000;
      sys_ctrl_r         <= 2'b00;
    end
    else if (wr_fire)
    begin
      if (hit(aw_addr_r, OFS_PERIOD_LOW))
        period_low_word_r <= merge16(period_low_word_r, w_data_r, w_strb_r);
      if (hit(aw_addr_r, OFS_PERIOD_HIGH))
        period_high_word_r <= merge16(period_high_word_r, w_data_r, w_strb_r);
      if (wr_lo_ctl)
        lower_ctrl_r <= merge16(lower_ctrl_r, w_data_r, w_strb_r);
      if (wr_hi_ctl)
        upper_ctrl_r <= merge16(upper_ctrl_r, w_data_r, w_strb_r);
      if (hit(aw_addr_r, OFS_IRQ_ENABLE))
        irq_enable_r <= merge16(irq_enable_r, w_data_r, w_strb_r);
      if (hit(aw_addr_r, OFS_SYS_CTRL) && w_strb_r[0])
        sys_ctrl_r <= w_data_r[1:0];
    end
  end

  // Sticky flag: hardware sets, software clears, set wins the tie
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_flag_r <= 16'h0000;
    else
    begin
      if (wr_fire && hit(aw_addr_r, OFS_IRQ_CLEAR))
        irq_flag_r <= irq_flag_r & ~merge16(16'h0000, w_data_r, w_strb_r);
      if (period_event && mode32 || gate_fall && lower_ctrl_r[CTL_GATE_ACC] && lo_on)
        irq_flag_r[IRQ_PERIOD_BIT] <= 1'b1;
    end
  end

  // Registered outputs: trigger strobe and level interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      adc_trigger <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      adc_trigger <= period_event;
      irq         <= |(irq_flag_r & irq_enable_r);
    end
  end

  // Write channels: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r <= OFS_SYS_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // Ready while the holding slot is empty and no response waits
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_r && !s_axi_bvalid;

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_COUNT_LOW:   s_axi_rdata <= {16'h0000, count_low_word_r};
        OFS_COUNT_HIGH:  s_axi_rdata <= {16'h0000, count_high_word_r};
        OFS_PERIOD_LOW:  s_axi_rdata <= {16'h0000, period_low_word_r};
        OFS_PERIOD_HIGH: s_axi_rdata <= {16'h0000, period_high_word_r};
        OFS_LOWER_CTRL:  s_axi_rdata <= {16'h0000, lower_ctrl_r};
        OFS_UPPER_CTRL:  s_axi_rdata <= {16'h0000, upper_ctrl_r};
        OFS_IRQ_STATUS:  s_axi_rdata <= {16'h0000, irq_flag_r};
        OFS_IRQ_ENABLE:  s_axi_rdata <= {16'h0000, irq_enable_r};
        OFS_IRQ_CLEAR:   s_axi_rdata <= 32'h0000_0000;             // Write only
        OFS_SYS_CTRL:    s_axi_rdata <= {30'h0000_0000, sys_ctrl_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;                            // Unmapped
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule // cgt_timer
`default_nettype wire

// ---- tb/cgt_far_side.sv ----
// Far-side model: gate and external clock source, ADC start counter
`timescale 1ns/1ns
`default_nettype none
module cgt_far_side
(
  input  wire logic aclk,
  input  wire logic adc_trigger,
  output logic      gate_input_pin
);
  int trig_cnt = 0;  // ADC starts seen
  // Gate idles low between pulses
  initial gate_input_pin = 1'b0;
  // Each strobe cycle starts one conversion
  always @(posedge aclk)
  begin
    if (adc_trigger === 1'b1) trig_cnt <= trig_cnt + 1;
  end
  // n pulses; changes land just after rising edges
  task automatic pulses(input int hi, input int lo, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge aclk);
      gate_input_pin <= 1'b1;
      repeat (hi) @(posedge aclk);
      gate_input_pin <= 1'b0;
      repeat (lo) @(posedge aclk);
    end
  endtask
endmodule // cgt_far_side
`default_nettype wire

// ---- tb/cgt_timer_asserts.sv ----
// Port-level assertions for the cascaded gated timer
`timescale 1ns/1ns
`default_nettype none
module cgt_timer_asserts
  import cgt_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        adc_trigger
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken at the same edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Commit edge, then the response shows
  sequence wr_resp;
    ##2 s_axi_bvalid;
  endsequence
  chk_trig_one_cycle: assert property (adc_trigger |=> !adc_trigger)
    else $error("adc trigger longer than one cycle");
  chk_write_answer: assert property (wr_taken |-> wr_resp)
    else $error("write response late");
  chk_write_unmapped: assert property (wr_taken ##0 (s_axi_awaddr[7:2] > OFS_SYS_CTRL[7:2])
    |-> wr_resp ##0 (s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > OFS_SYS_CTRL[7:2]
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  // Reset itself must be watched, so no disable here
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !adc_trigger)
    else $error("outputs active after reset");
endmodule // cgt_timer_asserts

bind cgt_timer cgt_timer_asserts chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .adc_trigger(adc_trigger));
`default_nettype wire

// ---- tb/cgt_timer_tb.sv ----
// Self-checking bench for the cascaded gated timer
`timescale 1ns/1ns
`default_nettype none
module cgt_timer_tb;
  import cgt_pkg::*;
  localparam logic [31:0] ON = 32'h8000;  // timer_on
  localparam logic [31:0] GT = 32'h0040;  // gate_accumulate_enable
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  wire logic   gate;
  wire logic   trig;
  wire logic   irq;
  logic [1:0]  last_resp;       // Response of the latest bus cycle
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // 125 MHz clock
  always #4 aclk = ~aclk;
  // Instruction clock every cycle keeps the prescale runs short
  cgt_timer #(.OSC_DIV(1)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gate_input_pin(gate),
    .adc_trigger(trig), .irq(irq));
  cgt_far_side far (.aclk(aclk), .adc_trigger(trig), .gate_input_pin(gate));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write; bready comes late so the held response is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (awvalid || wvalid || !bvalid)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    @(posedge aclk);
    last_resp = bresp;
    bready <= 1'b0;
  endtask
  // Read; data taken at the edge where rready is high
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (arvalid || !rvalid)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask
  task automatic t_reset();
    logic [7:0]  ofs [8];
    logic [31:0] exp [8];
    ofs = '{OFS_COUNT_LOW, OFS_COUNT_HIGH, OFS_PERIOD_LOW, OFS_PERIOD_HIGH, OFS_LOWER_CTRL, OFS_UPPER_CTRL,
      OFS_IRQ_STATUS, OFS_IRQ_ENABLE};
    exp = '{32'h0, 32'h0, 32'hffff, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) rd_check("reset value", ofs[i], exp[i]);
    wr(8'h28, 32'h1);
    check("unmapped write resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    rd_check("unmapped read", 8'h28, 32'h0);
    check("unmapped read resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(OFS_IRQ_STATUS, 32'h80);
    rd_check("status read only", OFS_IRQ_STATUS, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_carry();
    logic [31:0] v;
    wr(OFS_SYS_CTRL, 32'h2);
    wr(OFS_PERIOD_HIGH, 32'h2);
    wr(OFS_COUNT_LOW, 32'hfffe);
    wr(OFS_LOWER_CTRL, ON);
    repeat (10) @(posedge aclk);
    wr(OFS_LOWER_CTRL, 32'h0);
    rd_check("carry into upper", OFS_COUNT_HIGH, 32'h1);
    rd(OFS_COUNT_LOW, v);
    check("lower after carry", {31'h0, v < 32'h20}, 32'h1);
    wr(OFS_LOWER_CTRL, 32'h30);
    rd_check("count kept on ctrl write", OFS_COUNT_LOW, v);
    $display("test carry done");
  endtask
  task automatic t_sleep();
    logic [31:0] a;
    logic [31:0] c;
    wr(OFS_LOWER_CTRL, ON);
    wr(OFS_SYS_CTRL, 32'h3);
    rd(OFS_COUNT_LOW, a);
    repeat (20) @(posedge aclk);
    rd_check("frozen in sleep", OFS_COUNT_LOW, a);
    wr(OFS_SYS_CTRL, 32'h2);
    rd(OFS_COUNT_LOW, c);
    check("counts after wake", {31'h0, c > a}, 32'h1);
    $display("test sleep done");
  endtask
  task automatic t_match();
    int div;
    int n0;
    wr(OFS_LOWER_CTRL, 32'h0);
    wr(OFS_PERIOD_LOW, 32'h3);
    wr(OFS_PERIOD_HIGH, 32'h0);
    wr(OFS_COUNT_LOW, 32'h0);
    wr(OFS_COUNT_HIGH, 32'h0);
    wr(OFS_UPPER_CTRL, ON | GT | 32'h30);
    for (int p = 0; p < 4; p++)
    begin
      div = (p == 3) ? 256 : (1 << (3 * p));
      wr(OFS_LOWER_CTRL, ON | 32'(p << 4));
      repeat (8 * div) @(posedge aclk);
      n0 = far.trig_cnt;
      repeat (40 * div) @(posedge aclk);
      check("strobes per window", 32'(far.trig_cnt - n0), 32'd10);
    end
    wr(OFS_LOWER_CTRL, 32'h0);
    rd_check("match flag", OFS_IRQ_STATUS, 32'h80);
    wr(OFS_IRQ_CLEAR, 32'h80);
    rd_check("flag cleared", OFS_IRQ_STATUS, 32'h0);
    wr(OFS_SYS_CTRL, 32'h0);
    wr(OFS_PERIOD_HIGH, 32'h3);
    wr(OFS_UPPER_CTRL, ON);
    repeat (8) @(posedge aclk);
    n0 = far.trig_cnt;
    repeat (40) @(posedge aclk);
    check("16-bit strobes", 32'(far.trig_cnt - n0), 32'd10);
    wr(OFS_UPPER_CTRL, 32'h0);
    rd_check("no flag in 16-bit", OFS_IRQ_STATUS, 32'h0);
    $display("test match done");
  endtask
  task automatic t_gate();
    logic [31:0] a;
    wr(OFS_SYS_CTRL, 32'h2);
    wr(OFS_PERIOD_LOW, 32'hffff);
    wr(OFS_PERIOD_HIGH, 32'hffff);
    wr(OFS_COUNT_LOW, 32'h0);
    wr(OFS_COUNT_HIGH, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h80);
    wr(OFS_LOWER_CTRL, ON | GT);
    repeat (20) @(posedge aclk);
    rd_check("no count while gate low", OFS_COUNT_LOW, 32'h0);
    far.pulses(50, 1, 1);
    repeat (10) @(posedge aclk);
    rd(OFS_COUNT_LOW, a);
    check("gated count", {31'h0, a >= 32'd46 && a <= 32'd54}, 32'h1);
    repeat (20) @(posedge aclk);
    rd_check("kept after fall", OFS_COUNT_LOW, a);
    rd_check("fall flag", OFS_IRQ_STATUS, 32'h80);
    check("irq enabled", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge aclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h80);
    rd_check("fall flag cleared", OFS_IRQ_STATUS, 32'h0);
    wr(OFS_COUNT_LOW, 32'h0);
    rd_check("count zeroed by write", OFS_COUNT_LOW, 32'h0);
    $display("test gate done");
  endtask
  task automatic t_extclk();
    wr(OFS_LOWER_CTRL, 32'h0);
    wr(OFS_COUNT_LOW, 32'h0);
    wr(OFS_LOWER_CTRL, ON | 32'h2);
    far.pulses(4, 4, 5);
    repeat (10) @(posedge aclk);
    rd_check("external edges", OFS_COUNT_LOW, 32'h5);
    $display("test external clock done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the sum of the windows
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_carry();
    t_sleep();
    t_match();
    t_gate();
    t_extclk();
    wrap_up();
  end
endmodule // cgt_timer_tb
`default_nettype wire
